// ---- include/crl_consts.svh ----
// Purpose: constants of the calibration register loader
// Assumes: byte-wide nonvolatile store, 100 MHz clock
// Notes:   addresses are byte addresses of the 768-byte store
`ifndef CRL_CONSTS_SVH
`define CRL_CONSTS_SVH
`define CRL_NV_DEPTH     768
`define CRL_NV_PAGES     12
`define CRL_PAGE_BYTES   64
`define CRL_LOCK_NORMAL  8'hFF
`define CRL_LOCK_CAL     8'h00
`define CRL_PTR_MAX      8'hAF
`define CRL_PTR_SPLIT    8'h80
`define CRL_OFS_BASE     10'h000
`define CRL_OFS_LAST     10'h15F
`define CRL_SPAN_BASE_LO 10'h200
`define CRL_SPAN_LAST_LO 10'h2FF
`define CRL_SPAN_BASE_HI 10'h1A0
`define CRL_SPAN_LAST_HI 10'h1FF
`define CRL_ADDR_CONFIG  10'h160
`define CRL_ADDR_OTC     10'h164
`define CRL_ADDR_STC     10'h168
`define CRL_ADDR_LOCK    10'h16A
`define CRL_FB_SEL_BIT   0
`define CRL_REFRESH_NS   1000000
`define CRL_CLK_NS       10
`define CRL_CFG_RESET    16'h0000
`endif

// ---- include/crl_pkg.sv ----
// Purpose: types of the calibration register loader
// Assumes: used together with crl_consts.svh
// Notes:   register select codes match the serial write port
package crl_pkg;
	typedef enum logic [2:0] {
		CRL_IDLE  = 3'b000,
		CRL_RD_LO = 3'b001,
		CRL_RD_HI = 3'b010,
		CRL_STORE = 3'b011,
		CRL_NEXT  = 3'b100
	} crl_state_t;
	typedef enum logic [2:0] {
		CRL_R_CONFIG = 3'b000,
		CRL_R_OTC    = 3'b001,
		CRL_R_STC    = 3'b010,
		CRL_R_OFS    = 3'b011,
		CRL_R_SPAN   = 3'b100
	} crl_reg_t;
endpackage

// ---- hw/crl_loader.sv ----
// Purpose: fill five calibration registers from the store or serial host
// Assumes: store answers a read one cycle after the address is presented
// Notes:   erase is a per-page strobe passed to the store; no timing here
//
// Behaviour
// - five 16-bit calibration registers, filled from store or serial writes.
// - normal mode when lock byte is FFh and override pin is low.
// - after reset in normal mode, load all five registers first.
// - each refresh reloads config, offset tempco and span tempco words.
// - each refresh reloads offset and span trim from temperature tables.
// - refresh repeats every 1 ms tick of the temperature timer.
// - lock byte 00h or override high selects calibration mode.
// - store addressed as 768 locations of 8 bits.
// - store split in 12 pages of 64 bytes, each page erasable alone.
// - offset table spans bytes 000h to 15Fh.
// - span table spans 200h to 2FFh and 1A0h to 1FFh.
// - each word pairs adjacent low and high bytes.
// - one configuration bit selects internal or external feedback.
// - tempco registers take any code 0000h to FFFFh.
// - sensor reading becomes an 8-bit pointer every 1 ms.
// - pointer clamps at AFh, no wraparound.
// - each pointer selects two consecutive bytes forming one word.
`timescale 1ns/1ns
`include "crl_consts.svh"
module crl_loader
	import crl_pkg::*;
#(
	parameter int REFRESH_CYCLES = `CRL_REFRESH_NS / `CRL_CLK_NS
) (
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	input  wire logic        lock_override_i,
	input  wire logic [7:0]  temp_sample_i,
	input  wire logic [7:0]  nv_rdata_i,
	input  wire logic        ser_wr_i,
	input  wire logic [2:0]  ser_sel_i,
	input  wire logic [15:0] ser_data_i,
	input  wire logic        erase_req_i,
	input  wire logic [3:0]  erase_page_i,
	output logic      [9:0]  nv_addr_o,
	output logic             nv_rd_o,
	output logic             erase_o,
	output logic      [3:0]  erase_page_o,
	output logic      [15:0] config_word_o,
	output logic      [15:0] offset_tempco_code_o,
	output logic      [15:0] span_tempco_code_o,
	output logic      [15:0] offset_trim_code_o,
	output logic      [15:0] span_trim_code_o,
	output logic             feedback_internal_o,
	output logic             cal_mode_o,
	output logic             loaded_o,
	output logic      [7:0]  temp_pointer_o
);
	// refuse a refresh period shorter than 16 cycles
	if (REFRESH_CYCLES < 16) begin
		$error("REFRESH_CYCLES too small for a full load");
	end

	// ----------------------------------------------------------------
	// address helpers
	// ----------------------------------------------------------------
	// clamp a pointer to the highest table entry
	function automatic logic [7:0] clamp_ptr(input logic [7:0] p);
		clamp_ptr = (p > `CRL_PTR_MAX) ? `CRL_PTR_MAX : p;
	endfunction

	// low-byte address of a word for each register
	function automatic logic [9:0] word_addr(input crl_reg_t r,
			input logic [7:0] p);
		logic [9:0] twice;
		twice = {1'b0, p, 1'b0};
		case (r)
			CRL_R_CONFIG: word_addr = `CRL_ADDR_CONFIG;
			CRL_R_OTC:    word_addr = `CRL_ADDR_OTC;
			CRL_R_STC:    word_addr = `CRL_ADDR_STC;
			CRL_R_OFS:    word_addr = `CRL_OFS_BASE + twice;
			CRL_R_SPAN: begin
				if (p < `CRL_PTR_SPLIT)
					word_addr = `CRL_SPAN_BASE_LO + twice;
				else
					word_addr = `CRL_SPAN_BASE_HI + twice
						- {1'b0, `CRL_PTR_SPLIT, 1'b0};
			end
			default:      word_addr = `CRL_ADDR_CONFIG;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// mode selection
	// ----------------------------------------------------------------
	logic [7:0]  lock_byte_r;
	logic [7:0]  lock_byte_nxt;
	logic        lock_known_r;
	logic        lock_known_nxt;
	wire         lock_cal  = lock_known_r && lock_byte_r == `CRL_LOCK_CAL;
	wire         lock_norm = lock_known_r && lock_byte_r == `CRL_LOCK_NORMAL;
	// override wins; lock byte 00h forces calibration
	wire         cal_mode  = lock_override_i || lock_cal;
	wire         norm_mode = !lock_override_i && lock_norm;

	// ----------------------------------------------------------------
	// temperature timer and pointer
	// ----------------------------------------------------------------
	logic [31:0] tick_cnt_r;
	logic [7:0]  ptr_r;
	wire         tick = tick_cnt_r == 32'(REFRESH_CYCLES - 1);

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tick_cnt_r <= 32'h0;
			ptr_r      <= 8'h00;
		end else begin
			tick_cnt_r <= tick ? 32'h0 : tick_cnt_r + 32'h1;
			if (tick)
				ptr_r <= clamp_ptr(temp_sample_i);
		end
	end

	// ----------------------------------------------------------------
	// load sequencer
	// ----------------------------------------------------------------
	crl_state_t  state_r;
	crl_state_t  state_nxt;
	crl_reg_t    sel_r;
	crl_reg_t    sel_nxt;
	logic        first_r;
	logic        first_nxt;
	logic        pend_r;
	logic        pend_nxt;
	logic        lock_ph_r;
	logic        lock_ph_nxt;
	logic [7:0]  lo_r;
	logic [7:0]  lo_nxt;
	logic        loaded_r;
	logic        loaded_nxt;
	logic [9:0]  addr_nxt;
	logic        rd_nxt;
	logic [15:0] cal_r [5];
	wire  [9:0]  base   = lock_ph_r ? `CRL_ADDR_LOCK : word_addr(sel_r, ptr_r);
	wire  [15:0] word   = {nv_rdata_i, lo_r};
	wire         st_wr  = state_r == CRL_STORE && !lock_ph_r;
	// refresh only while in normal mode
	wire         go     = pend_r && (lock_ph_r || norm_mode);

	always_comb begin
		state_nxt      = state_r;
		sel_nxt        = sel_r;
		first_nxt      = first_r;
		pend_nxt       = pend_r || (tick && !first_r);
		lock_ph_nxt    = lock_ph_r;
		lock_byte_nxt  = lock_byte_r;
		lock_known_nxt = lock_known_r;
		lo_nxt         = lo_r;
		loaded_nxt     = loaded_r;
		addr_nxt       = base;
		rd_nxt         = 1'b0;
		case (state_r)
			CRL_IDLE: begin
				if (go) begin
					rd_nxt    = 1'b1;
					state_nxt = CRL_RD_LO;
				end else if (pend_r && cal_mode) begin
					pend_nxt = 1'b0;
				end
			end
			CRL_RD_LO: begin
				// high byte follows the low byte even if the pointer moved
				addr_nxt  = nv_addr_o + 10'h001;
				rd_nxt    = 1'b1;
				state_nxt = CRL_RD_HI;
			end
			CRL_RD_HI: begin
				// low byte stands in the cycle after its read strobe
				lo_nxt    = nv_rdata_i;
				state_nxt = CRL_STORE;
			end
			CRL_STORE: begin
				if (lock_ph_r) begin
					lock_byte_nxt  = lo_r;
					lock_known_nxt = 1'b1;
					lock_ph_nxt    = 1'b0;
					state_nxt      = CRL_IDLE;
				end else
					state_nxt = CRL_NEXT;
			end
			CRL_NEXT: begin
				if (sel_r == CRL_R_SPAN) begin
					sel_nxt    = CRL_R_CONFIG;
					pend_nxt   = tick; // a tick on the last word is queued
					first_nxt  = 1'b0;
					loaded_nxt = 1'b1;
					state_nxt  = CRL_IDLE;
				end else begin
					sel_nxt   = crl_reg_t'(sel_r + 3'b001);
					rd_nxt    = 1'b1;
					addr_nxt  = word_addr(crl_reg_t'(sel_r + 3'b001), ptr_r);
					state_nxt = CRL_RD_LO;
				end
			end
			default: state_nxt = CRL_IDLE;
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r      <= CRL_IDLE;
			sel_r        <= CRL_R_CONFIG;
			first_r      <= 1'b1;
			pend_r       <= 1'b1;
			lock_ph_r    <= 1'b1;
			lock_byte_r  <= 8'h00;
			lock_known_r <= 1'b0;
			lo_r         <= 8'h00;
			loaded_r     <= 1'b0;
			nv_addr_o    <= `CRL_ADDR_LOCK;
			nv_rd_o      <= 1'b0;
		end else begin
			state_r      <= state_nxt;
			sel_r        <= sel_nxt;
			first_r      <= first_nxt;
			pend_r       <= pend_nxt;
			lock_ph_r    <= lock_ph_nxt;
			lock_byte_r  <= lock_byte_nxt;
			lock_known_r <= lock_known_nxt;
			lo_r         <= lo_nxt;
			loaded_r     <= loaded_nxt;
			nv_addr_o    <= addr_nxt;
			nv_rd_o      <= rd_nxt;
		end
	end

	// ----------------------------------------------------------------
	// calibration registers
	// ----------------------------------------------------------------
	// store words from the sequencer, or serial writes in calibration mode
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < 5; i++)
				cal_r[i] <= `CRL_CFG_RESET;
		end else if (st_wr) begin
			cal_r[sel_r] <= word;
		end else if (ser_wr_i && cal_mode && ser_sel_i <= 3'(CRL_R_SPAN)) begin
			cal_r[ser_sel_i] <= ser_data_i;
		end
	end

	// page erase strobe towards the store
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			erase_o      <= 1'b0;
			erase_page_o <= 4'h0;
		end else begin
			erase_o      <= erase_req_i && cal_mode
				&& erase_page_i < 4'(`CRL_NV_PAGES);
			erase_page_o <= erase_page_i;
		end
	end

	assign config_word_o        = cal_r[CRL_R_CONFIG];
	assign offset_tempco_code_o = cal_r[CRL_R_OTC];
	assign span_tempco_code_o   = cal_r[CRL_R_STC];
	assign offset_trim_code_o   = cal_r[CRL_R_OFS];
	assign span_trim_code_o     = cal_r[CRL_R_SPAN];
	assign feedback_internal_o  = cal_r[CRL_R_CONFIG][`CRL_FB_SEL_BIT];
	assign cal_mode_o           = cal_mode;
	assign loaded_o             = loaded_r;
	assign temp_pointer_o       = ptr_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_ptr_clamped: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		ptr_r <= `CRL_PTR_MAX) else $error("pointer above table end");
	a_ptr_update: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		tick |=> ptr_r == clamp_ptr($past(temp_sample_i)))
		else $error("pointer not taken on tick");
	a_addr_range: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		nv_rd_o |-> nv_addr_o < 10'(`CRL_NV_DEPTH))
		else $error("store address out of range");
	a_ofs_table: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		st_wr && sel_r == CRL_R_OFS |-> $past(nv_addr_o, 2) <= `CRL_OFS_LAST)
		else $error("offset read outside table");
	a_span_table: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		st_wr && sel_r == CRL_R_SPAN
		|-> $past(nv_addr_o, 2) >= `CRL_SPAN_BASE_HI)
		else $error("span read outside table");
	a_word_pair: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		state_r == CRL_RD_LO
		|=> nv_rd_o && nv_addr_o == $past(nv_addr_o) + 10'h001)
		else $error("high byte not adjacent");
	a_cal_no_load: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		cal_mode && state_r == CRL_IDLE && !lock_ph_r |=> !nv_rd_o)
		else $error("refresh in calibration mode");
	a_first_load: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		$rose(loaded_r) |-> $past(sel_r) == CRL_R_SPAN)
		else $error("loaded before all five words");
	a_fb_bit: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		feedback_internal_o == config_word_o[`CRL_FB_SEL_BIT])
		else $error("feedback select mismatch");
	a_norm_mode: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		norm_mode |-> !cal_mode) else $error("modes overlap");
	a_refresh_go: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		state_r == CRL_IDLE && pend_r && norm_mode && !lock_ph_r
		|=> nv_rd_o && nv_addr_o == $past(base))
		else $error("refresh not started in normal mode");
	a_tick_queued: assert property (
		@(posedge clock_i) disable iff (!rst_n_i)
		tick && !first_r && !cal_mode |=> pend_r)
		else $error("refresh tick lost");
endmodule

// ---- test/crl_nv_model.sv ----
// Purpose: byte-wide store model on the far side of the loader
// Assumes: read data is due in the cycle after the read strobe
// Notes:   idle data lines toggle so late sampling shows up
`timescale 1ns/1ns
module crl_nv_model (
	input  wire logic       clock_i,
	input  wire logic       nv_rd_i,
	input  wire logic [9:0] nv_addr_i,
	input  wire logic       erase_i,
	input  wire logic [3:0] erase_page_i,
	input  wire logic [7:0] lock_byte_i,
	output logic      [7:0] rdata_o
);
	logic [11:0] erased_r = 12'h000;
	// ---------------------------------------------------------------
	// contents and read port
	// ---------------------------------------------------------------
	// contents stand for coefficients put in place by the host
	function automatic logic [7:0] byte_of(input logic [9:0] a);
		if (a == 10'h16A) return lock_byte_i;
		if (erased_r[a[9:6]]) return 8'hFF; // 64-byte pages
		return a[7:0] ^ {a[9:8], 6'h15}; // 768 bytes of 8 bits
	endfunction
	initial rdata_o = 8'h5A;
	// answer one cycle later, otherwise the lines do not hold
	always @(posedge clock_i) begin
		if (nv_rd_i) rdata_o <= byte_of(nv_addr_i);
		else rdata_o <= ~rdata_o;
	end
	// each page is erased on its own
	always @(posedge clock_i) begin
		if (erase_i && erase_page_i < 4'hC) erased_r[erase_page_i] <= 1'b1;
	end
endmodule

// ---- test/crl_loader_tb_top.sv ----
// Purpose: self-checking bench of the calibration register loader
// Assumes: shortened refresh period, store model on the far side
// Notes:   ordinary cases come from a table of temperature samples
`timescale 1ns/1ns
`include "crl_consts.svh"
module crl_loader_tb_top;
	localparam int RC = 32; // shortened refresh period
	typedef struct packed {
		logic [7:0] temp;
		logic [7:0] ptr;
	} crl_row_t;
	crl_row_t    rows [6] = '{'{8'h00, 8'h00}, '{8'h7F, 8'h7F},
		'{8'h80, 8'h80}, '{8'hAF, 8'hAF}, '{8'hB0, 8'hAF}, '{8'hFF, 8'hAF}};
	logic        clock_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        lock_override_i = 1'b0;
	logic        ser_wr_i = 1'b0;
	logic        erase_req_i = 1'b0;
	logic [2:0]  ser_sel_i = 3'h0;
	logic [3:0]  erase_page_i = 4'h0;
	logic [7:0]  temp_sample_i = 8'h00;
	logic [7:0]  lock_byte = 8'hFF;
	logic [15:0] ser_data_i = 16'h0000;
	logic [7:0]  nv_rdata_i, tptr;
	logic [9:0]  nv_addr_o;
	logic        nv_rd_o, erase_o, fb, cal_mode_o, loaded_o;
	logic [3:0]  erase_page_o;
	logic [15:0] cfg, otc, stc, ofs, spn;
	int          n_mismatch = 0;
	int          checks = 0;
	int          cycles = 0;
	always #5 clock_i = ~clock_i;
	crl_loader #(.REFRESH_CYCLES(RC)) dut (.clock_i(clock_i),
		.rst_n_i(rst_n_i), .lock_override_i(lock_override_i),
		.temp_sample_i(temp_sample_i), .nv_rdata_i(nv_rdata_i),
		.ser_wr_i(ser_wr_i), .ser_sel_i(ser_sel_i), .ser_data_i(ser_data_i),
		.erase_req_i(erase_req_i), .erase_page_i(erase_page_i),
		.nv_addr_o(nv_addr_o), .nv_rd_o(nv_rd_o), .erase_o(erase_o),
		.erase_page_o(erase_page_o), .config_word_o(cfg),
		.offset_tempco_code_o(otc), .span_tempco_code_o(stc),
		.offset_trim_code_o(ofs), .span_trim_code_o(spn),
		.feedback_internal_o(fb), .cal_mode_o(cal_mode_o),
		.loaded_o(loaded_o), .temp_pointer_o(tptr));
	crl_nv_model nv (.clock_i(clock_i), .nv_rd_i(nv_rd_o),
		.nv_addr_i(nv_addr_o), .erase_i(erase_o), .erase_page_i(erase_page_o),
		.lock_byte_i(lock_byte), .rdata_o(nv_rdata_i));
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// cut a hang short
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [7:0] b(input logic [9:0] a);
		return a[7:0] ^ {a[9:8], 6'h15};
	endfunction
	function automatic logic [15:0] word(input logic [9:0] a);
		return {b(a | 10'h001), b(a)};
	endfunction
	function automatic logic [9:0] span_a(input logic [7:0] p);
		if (p < `CRL_PTR_SPLIT) return `CRL_SPAN_BASE_LO + {1'b0, p, 1'b0};
		return `CRL_SPAN_BASE_HI + {1'b0, p - `CRL_PTR_SPLIT, 1'b0};
	endfunction
	task automatic check_all(input logic [7:0] p);
		logic [15:0] c;
		c = word(`CRL_ADDR_CONFIG);
		check("config", cfg, c);
		check("feedback", {15'h0, fb}, {15'h0, c[`CRL_FB_SEL_BIT]});
		check("offset tempco", otc, word(`CRL_ADDR_OTC));
		check("span tempco", stc, word(`CRL_ADDR_STC));
		check("offset trim", ofs, word({1'b0, p, 1'b0}));
		check("span trim", spn, word(span_a(p)));
	endtask
	task automatic ser_write(input logic [2:0] s, input logic [15:0] d);
		@(posedge clock_i);
		ser_wr_i <= 1'b1;
		ser_sel_i <= s;
		ser_data_i <= d;
		@(posedge clock_i);
		ser_wr_i <= 1'b0;
	endtask
	task automatic erase(input logic [3:0] pg);
		@(posedge clock_i);
		erase_req_i <= 1'b1;
		erase_page_i <= pg;
		@(posedge clock_i);
		erase_req_i <= 1'b0;
		@(negedge clock_i);
	endtask
	// ---------------------------------------------------------------
	// stimulus
	// ---------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clock_i);
		check("reset config", cfg, 16'h0000);
		check("reset mode", {15'h0, cal_mode_o}, 16'h0000);
		rst_n_i <= 1'b1;
		for (int i = 0; i < 200 && loaded_o !== 1'b1; i++) @(negedge clock_i);
		check("loaded", {15'h0, loaded_o}, 16'h0001);
		check_all(8'h00);
		// table of temperature samples, pointer clamps at the top
		foreach (rows[i]) begin
			@(posedge clock_i);
			temp_sample_i <= rows[i].temp;
			repeat (2 * RC + 40) @(negedge clock_i);
			check("pointer", {8'h00, tptr}, {8'h00, rows[i].ptr});
			check_all(rows[i].ptr);
		end
		ser_write(3'h0, 16'hA5A5);
		@(negedge clock_i);
		check("refused write", cfg, word(`CRL_ADDR_CONFIG));
		@(posedge clock_i);
		lock_override_i <= 1'b1;
		repeat (40) @(negedge clock_i);
		check("override mode", {15'h0, cal_mode_o}, 16'h0001);
		for (int s = 0; s < 6; s++) ser_write(3'(s), {4{4'(s * 5)}});
		repeat (2 * RC + 40) @(negedge clock_i);
		check("cal config", cfg, 16'h0000);
		check("cal feedback", {15'h0, fb}, 16'h0000);
		check("cal tempco", otc, 16'h5555);
		check("cal tempco", stc, 16'hAAAA);
		check("cal trim", ofs, 16'hFFFF);
		check("cal trim", spn, 16'h4444);
		erase(4'h5);
		check("erase", {11'h0, erase_o, erase_page_o}, 16'h0015);
		erase(4'hC);
		check("erase range", {15'h0, erase_o}, 16'h0000);
		@(posedge clock_i);
		lock_override_i <= 1'b0;
		repeat (2 * RC + 40) @(negedge clock_i);
		check("erased config", cfg, 16'hFFFF);
		check("erased trim", ofs, 16'hFFFF);
		@(posedge clock_i);
		rst_n_i <= 1'b0;
		lock_byte <= 8'h00;
		repeat (8) @(posedge clock_i);
		rst_n_i <= 1'b1;
		repeat (20) @(negedge clock_i);
		check("lock mode", {15'h0, cal_mode_o}, 16'h0001);
		ser_write(3'h3, 16'hBEEF);
		repeat (2 * RC + 40) @(negedge clock_i);
		check("held trim", ofs, 16'hBEEF);
		// lock byte of neither value: no load and no serial access
		@(posedge clock_i);
		rst_n_i <= 1'b0;
		lock_byte <= 8'h5A;
		repeat (8) @(posedge clock_i);
		rst_n_i <= 1'b1;
		repeat (2 * RC + 40) @(negedge clock_i);
		check("odd lock mode", {15'h0, cal_mode_o}, 16'h0000);
		check("odd lock load", {15'h0, loaded_o}, 16'h0000);
		ser_write(3'h3, 16'h1234);
		@(negedge clock_i);
		check("odd lock write", ofs, 16'h0000);
		end_of_test();
	end
endmodule
